// ---- src/smcs_control_status.sv ----
`timescale 1ns/10ps
module smcs_control_status
  import smcs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWe,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe
);

  smcs_state_t state_q;
  smcs_state_t state_d;
  logic [15:0] tmr_q;
  logic [15:0] tmr_d;
  logic [3:0]  bitCnt_q;
  logic [3:0]  bitCnt_d;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic [7:0]  data_q;
  logic [7:0]  data_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        role_q;
  logic        role_d;
  logic        tx_q;
  logic        tx_d;
  logic        sta_q;
  logic        sta_d;
  logic        sto_q;
  logic        sto_d;
  logic        ackrq_q;
  logic        ackrq_d;
  logic        arbl_q;
  logic        arbl_d;
  logic        ack_q;
  logic        ack_d;
  logic        si_q;
  logic        si_d;
  logic        hwAck_q;
  logic        hwAck_d;
  logic        busy_q;
  logic        busy_d;
  logic        adr_q;
  logic        adr_d;
  logic        rw_q;
  logic        rw_d;
  logic        sclOe_q;
  logic        sclOe_d;
  logic        sdaOe_q;
  logic        sdaOe_d;
  logic        pinLow_q;
  logic        sclM_q;
  logic        sclS_q;
  logic        sclP_q;
  logic        sdaM_q;
  logic        sdaS_q;
  logic        sdaP_q;
  logic        ctrlWr;
  logic        siClr;
  logic        tmrDone;
  logic        sclRise;
  logic        sclFall;
  logic        startDet;
  logic        stopDet;
  logic        staSet;
  logic        stoSet;
  logic        stoClr;
  logic        siSet;
  logic        arbSet;
  logic        rqSet;
  logic        ackLoad;
  logic        ackVal;

  assign sfrRdata = rdata_q;
  assign sclOut   = pinLow_q;
  assign sdaOut   = pinLow_q;
  assign sclOe    = sclOe_q;
  assign sdaOe    = sdaOe_q;

  // pin synchronisers, then edge and condition detect
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclM_q <= 1'b1;
      sclS_q <= 1'b1;
      sclP_q <= 1'b1;
      sdaM_q <= 1'b1;
      sdaS_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclM_q <= sclIn;
      sclS_q <= sclM_q;
      sclP_q <= sclS_q;
      sdaM_q <= sdaIn;
      sdaS_q <= sdaM_q;
      sdaP_q <= sdaS_q;
    end
  end

  assign sclRise  = sclS_q & ~sclP_q;
  assign sclFall  = ~sclS_q & sclP_q;
  assign startDet = sclS_q & sclP_q & sdaP_q & ~sdaS_q;
  assign stopDet  = sclS_q & sclP_q & ~sdaP_q & sdaS_q;
  assign ctrlWr   = sfrWe && (sfrAddr == CTRL_ADDR);
  assign siClr    = ctrlWr && !sfrWdata[BIT_SI];
  assign tmrDone  = (tmr_q == 16'h0000);

  always_comb begin
    state_d  = state_q;
    tmr_d    = tmrDone ? tmr_q : tmr_q - 16'h0001;
    bitCnt_d = bitCnt_q;
    shift_d  = shift_q;
    data_d   = data_q;
    role_d   = role_q;
    tx_d     = tx_q;
    adr_d    = adr_q;
    rw_d     = rw_q;
    sclOe_d  = 1'b0;
    sdaOe_d  = sdaOe_q;
    staSet   = 1'b0;
    stoSet   = 1'b0;
    stoClr   = 1'b0;
    siSet    = 1'b0;
    arbSet   = 1'b0;
    rqSet    = 1'b0;
    ackLoad  = 1'b0;
    ackVal   = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (startDet) begin
          staSet   = 1'b1;
          siSet    = 1'b1;
          role_d   = 1'b0;
          tx_d     = 1'b0;
          bitCnt_d = 4'h0;
          state_d  = S_SLV;
        end else if (sta_q && !si_q && !busy_q) begin
          role_d  = 1'b1;
          tx_d    = 1'b1;
          state_d = S_START;
        end
      end
      S_START: begin
        sdaOe_d = 1'b1;
        if (tmrDone) begin
          sclOe_d  = 1'b1;
          siSet    = 1'b1;
          adr_d    = 1'b1;
          bitCnt_d = 4'h0;
          state_d  = S_HOLD;
        end
      end
      S_HOLD: begin
        sclOe_d = 1'b1;
        if (!si_q) begin
          if (bitCnt_q == ACK_SLOT) begin
            state_d = S_LOW;
          end else if (sto_q) begin
            state_d = S_STOP1;
          end else if (sta_q) begin
            state_d = S_RSTA1;
          end else begin
            shift_d = tx_q ? data_q : 8'h00;
            if (adr_q) begin
              rw_d = data_q[0];
            end
            state_d = S_LOW;
          end
        end
      end
      S_LOW: begin
        sclOe_d = 1'b1;
        if (bitCnt_q == ACK_SLOT) begin
          sdaOe_d = !tx_q && ack_q;
        end else begin
          sdaOe_d = tx_q && !shift_q[7];
        end
        if (tmrDone) begin
          state_d = S_RISE;
        end
      end
      S_RISE: begin
        if (sclS_q) begin
          state_d = S_HIGH;
          if (bitCnt_q == ACK_SLOT) begin
            ackLoad = tx_q;
            ackVal  = !sdaS_q;
          end else if (tx_q && shift_q[7] && !sdaS_q) begin
            arbSet  = 1'b1;
            rqSet   = !hwAck_q;
            siSet   = 1'b1;
            role_d  = 1'b0;
            tx_d    = 1'b0;
            sdaOe_d = 1'b0;
            state_d = S_IDLE;
          end else begin
            shift_d = {shift_q[6:0], sdaS_q};
          end
        end
      end
      S_HIGH: begin
        if (tmrDone) begin
          sclOe_d = 1'b1;
          if (bitCnt_q == ACK_SLOT) begin
            bitCnt_d = 4'h0;
            adr_d    = 1'b0;
            if (!tx_q) begin
              data_d = shift_q;
            end
            if (tx_q || hwAck_q) begin
              siSet   = 1'b1;
              state_d = S_HOLD;
              if (adr_q && ack_q && rw_q) begin
                tx_d = 1'b0;
              end
            end else if (sto_q) begin
              state_d = S_STOP1;
            end else if (sta_q) begin
              state_d = S_RSTA1;
            end else begin
              state_d = S_LOW;
            end
          end else if (bitCnt_q == LAST_BIT && !tx_q && !hwAck_q) begin
            bitCnt_d = ACK_SLOT;
            data_d   = shift_q;
            siSet    = 1'b1;
            rqSet    = 1'b1;
            state_d  = S_HOLD;
          end else begin
            bitCnt_d = bitCnt_q + 4'h1;
            state_d  = S_LOW;
          end
        end
      end
      S_RSTA1: begin
        sclOe_d = 1'b1;
        sdaOe_d = 1'b0;
        if (tmrDone) begin
          state_d = S_RSTA2;
        end
      end
      S_RSTA2: begin
        if (sclS_q && tmrDone) begin
          if (!sdaS_q) begin
            arbSet  = 1'b1;
            siSet   = 1'b1;
            role_d  = 1'b0;
            tx_d    = 1'b0;
            state_d = S_IDLE;
          end else begin
            tx_d    = 1'b1;
            state_d = S_START;
          end
        end
      end
      S_STOP1: begin
        sclOe_d = 1'b1;
        sdaOe_d = 1'b1;
        if (tmrDone) begin
          state_d = S_STOP2;
        end
      end
      S_STOP2: begin
        if (sclS_q && tmrDone) begin
          state_d = S_STOP3;
        end
      end
      S_STOP3: begin
        sdaOe_d = 1'b0;
        if (tmrDone) begin
          stoClr  = 1'b1;
          role_d  = 1'b0;
          tx_d    = 1'b0;
          state_d = S_IDLE;
        end
      end
      S_SLV: begin
        if (stopDet) begin
          stoSet  = 1'b1;
          siSet   = 1'b1;
          state_d = S_IDLE;
        end else if (startDet) begin
          staSet   = 1'b1;
          siSet    = 1'b1;
          bitCnt_d = 4'h0;
        end else if (sclRise && bitCnt_q != ACK_SLOT) begin
          shift_d  = {shift_q[6:0], sdaS_q};
          bitCnt_d = bitCnt_q + 4'h1;
        end else if (sclFall && bitCnt_q == ACK_SLOT) begin
          data_d  = shift_q;
          siSet   = 1'b1;
          rqSet   = !hwAck_q;
          state_d = S_SACK;
        end
      end
      S_SACK: begin
        if (!si_q) begin
          sdaOe_d = ack_q;
          if (sclFall) begin
            sdaOe_d  = 1'b0;
            bitCnt_d = 4'h0;
            state_d  = S_SLV;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (role_q && stopDet && !(state_q inside {S_STOP1, S_STOP2, S_STOP3})) begin
      arbSet  = 1'b1;
      stoSet  = 1'b1;
      siSet   = 1'b1;
      rqSet   = 1'b0;
      role_d  = 1'b0;
      tx_d    = 1'b0;
      sdaOe_d = 1'b0;
      state_d = S_IDLE;
    end
    if (si_q && busy_q) begin
      sclOe_d = 1'b1;
    end
    if (state_d != state_q) begin
      tmr_d = HALF_LOAD;
    end
    if (sfrWe && sfrAddr == DATA_ADDR) begin
      data_d = sfrWdata;
    end
    busy_d  = startDet ? 1'b1 : (stopDet ? 1'b0 : busy_q);
    hwAck_d = (sfrWe && sfrAddr == CFG_ADDR) ? sfrWdata[BIT_HWACK] : hwAck_q;
    sta_d   = staSet | (ctrlWr ? sfrWdata[BIT_STA] : sta_q);
    sto_d   = stoSet | (ctrlWr ? sfrWdata[BIT_STO] : (sto_q & ~stoClr));
    ack_d   = ctrlWr ? sfrWdata[BIT_ACK] : (ackLoad ? ackVal : ack_q);
    si_d    = siSet | (ctrlWr ? sfrWdata[BIT_SI] : si_q);
    arbl_d  = arbSet | (arbl_q & ~siClr);
    ackrq_d = rqSet | (ackrq_q & ~siClr);
    unique case (sfrAddr)
      CTRL_ADDR: rdata_d = {role_q, tx_q, sta_q, sto_q, ackrq_q, arbl_q, ack_q, si_q};
      CFG_ADDR:  rdata_d = {7'h00, hwAck_q};
      DATA_ADDR: rdata_d = data_q;
      default:   rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q  <= S_IDLE;
      tmr_q    <= 16'h0000;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
      data_q   <= DATA_RESET;
      rdata_q  <= 8'h00;
      role_q   <= CTRL_RESET[BIT_ROLE];
      tx_q     <= CTRL_RESET[BIT_DIR];
      sta_q    <= CTRL_RESET[BIT_STA];
      sto_q    <= CTRL_RESET[BIT_STO];
      ackrq_q  <= CTRL_RESET[BIT_ACKRQ];
      arbl_q   <= CTRL_RESET[BIT_ARBL];
      ack_q    <= CTRL_RESET[BIT_ACK];
      si_q     <= CTRL_RESET[BIT_SI];
      hwAck_q  <= HWACK_RESET;
      busy_q   <= 1'b0;
      adr_q    <= 1'b0;
      rw_q     <= 1'b0;
      sclOe_q  <= 1'b0;
      sdaOe_q  <= 1'b0;
      pinLow_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      tmr_q    <= tmr_d;
      bitCnt_q <= bitCnt_d;
      shift_q  <= shift_d;
      data_q   <= data_d;
      rdata_q  <= rdata_d;
      role_q   <= role_d;
      tx_q     <= tx_d;
      sta_q    <= sta_d;
      sto_q    <= sto_d;
      ackrq_q  <= ackrq_d;
      arbl_q   <= arbl_d;
      ack_q    <= ack_d;
      si_q     <= si_d;
      hwAck_q  <= hwAck_d;
      busy_q   <= busy_d;
      adr_q    <= adr_d;
      rw_q     <= rw_d;
      sclOe_q  <= sclOe_d;
      sdaOe_q  <= sdaOe_d;
      pinLow_q <= 1'b0;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence reqStart_s;
    state_q == S_IDLE && sta_q && !si_q && !busy_q && !startDet;
  endsequence
  sequence lostRsta_s;
    state_q == S_RSTA2 && sclS_q && tmrDone && !sdaS_q;
  endsequence

  status_vector_a: assert property ((sfrAddr == CTRL_ADDR) |=>
    sfrRdata[7:4] == {$past(role_q), $past(tx_q), $past(sta_q), $past(sto_q)})
    else $error("status vector read mismatch");
  start_detect_a: assert property (state_q == S_IDLE && startDet |=>
    sta_q && si_q && !role_q && state_q == S_SLV)
    else $error("foreign start not flagged");
  start_request_a: assert property (reqStart_s |=>
    state_q == S_START && role_q && tx_q)
    else $error("start request not taken");
  start_vector_a: assert property (state_q == S_START && tmrDone && !ctrlWr |=>
    state_q == S_HOLD && si_q && role_q && tx_q && sta_q)
    else $error("vector 1110 not shown after start");
  stop_done_a: assert property (state_q == S_STOP3 && tmrDone && !ctrlWr |=>
    !sto_q && !role_q && state_q == S_IDLE)
    else $error("stop flag not cleared after stop");
  clock_stall_a: assert property (si_q && busy_q |=> sclOe_q)
    else $error("clock line released while interrupt pending");
  si_force_a: assert property (ctrlWr && sfrWdata[BIT_SI] |=> si_q)
    else $error("forced interrupt not set");
  si_sticky_a: assert property (si_q && !ctrlWr |=> si_q)
    else $error("interrupt flag cleared without software");
  rsta_loss_a: assert property (lostRsta_s |=>
    arbl_q && si_q && !role_q && !tx_q && state_q == S_IDLE)
    else $error("repeated start loss not reported");
  ack_request_a: assert property (ackrq_q |-> si_q)
    else $error("ack request without interrupt");
  stop_loss_a: assert property (role_q && stopDet &&
    !(state_q inside {S_STOP1, S_STOP2, S_STOP3}) |=>
    arbl_q && sto_q && si_q && !role_q && state_q == S_IDLE)
    else $error("foreign stop loss not reported");

endmodule

// ---- src/smcs_pkg.sv ----
package smcs_pkg;
  localparam logic [7:0]  CTRL_ADDR   = 8'hc0;
  localparam logic [7:0]  CFG_ADDR    = 8'hc1;
  localparam logic [7:0]  DATA_ADDR   = 8'hc2;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic        HWACK_RESET = 1'h0;
  localparam int          BIT_ROLE    = 7;
  localparam int          BIT_DIR     = 6;
  localparam int          BIT_STA     = 5;
  localparam int          BIT_STO     = 4;
  localparam int          BIT_ACKRQ   = 3;
  localparam int          BIT_ARBL    = 2;
  localparam int          BIT_ACK     = 1;
  localparam int          BIT_SI      = 0;
  localparam int          BIT_HWACK   = 0;
  localparam int          CLK_NS      = 10;
  localparam int          HALF_NS     = 5000;
  localparam int          HALF_CYC    = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] HALF_LOAD   = 16'(HALF_CYC - 1);
  localparam logic [3:0]  ACK_SLOT    = 4'h8;
  localparam logic [3:0]  LAST_BIT    = 4'h7;
  typedef enum logic [12:0] {
    S_IDLE  = 13'h0001,
    S_START = 13'h0002,
    S_HOLD  = 13'h0004,
    S_LOW   = 13'h0008,
    S_RISE  = 13'h0010,
    S_HIGH  = 13'h0020,
    S_RSTA1 = 13'h0040,
    S_RSTA2 = 13'h0080,
    S_STOP1 = 13'h0100,
    S_STOP2 = 13'h0200,
    S_STOP3 = 13'h0400,
    S_SLV   = 13'h0800,
    S_SACK  = 13'h1000
  } smcs_state_t;
endpackage

// ---- sim/smcs_bus_partner.sv ----
`timescale 1ns/10ps
module smcs_bus_partner (
  input  wire logic sclOe,
  input  wire logic sdaOe,
  input  wire logic holdSclLow,
  input  wire logic holdSdaLow,
  input  wire logic ackEn,
  output wire logic scl,
  output wire logic sda
);
  logic ackPull = 1'b0;
  int   riseCnt = 0;

  // open-drain lines, pull-ups win when nobody pulls
  assign scl = ~(sclOe | holdSclLow);
  assign sda = ~(sdaOe | holdSdaLow | ackPull);

  // start condition restarts the slot count
  always @(negedge sda) begin
    if (scl)
      riseCnt = 0;
  end

  always @(posedge scl) begin
    riseCnt++;
  end

  // slave pulls data low through the ninth slot
  always @(negedge scl) begin
    ackPull = ackEn && riseCnt == 8;
    if (riseCnt >= 9)
      riseCnt = 0;
  end
endmodule

// ---- sim/test_smcs_control_status.sv ----
`timescale 1ns/10ps
module test_smcs_control_status
  import smcs_pkg::*;
;
  logic       clk_sys;
  logic       rst;
  logic [7:0] sfrAddr;
  logic       sfrWe;
  logic [7:0] sfrWdata;
  logic [7:0] sfrRdata;
  logic       sclOe;
  logic       sdaOe;
  logic       holdSclLow;
  logic       holdSdaLow;
  logic       ackEn;
  wire        scl;
  wire        sda;
  int         error_cnt;
  int         samples_checked;
  logic [7:0] rv;
  logic       bv;

  smcs_control_status i_smcs_control_status (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .sfrAddr  (sfrAddr),
    .sfrWe    (sfrWe),
    .sfrWdata (sfrWdata),
    .sfrRdata (sfrRdata),
    .sclIn    (scl),
    .sclOut   (),
    .sclOe    (sclOe),
    .sdaIn    (sda),
    .sdaOut   (),
    .sdaOe    (sdaOe)
  );

  smcs_bus_partner i_smcs_bus_partner (
    .sclOe      (sclOe),
    .sdaOe      (sdaOe),
    .holdSclLow (holdSclLow),
    .holdSdaLow (holdSdaLow),
    .ackEn      (ackEn),
    .scl        (scl),
    .sda        (sda)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfrAddr = a;
    sfrWe = 1'b1;
    sfrWdata = d;
    @(posedge clk_sys);
    #1;
    sfrWe = 1'b0;
    sfrAddr = CTRL_ADDR;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfrAddr = a;
    @(posedge clk_sys);
    #1;
    d = sfrRdata;
    sfrAddr = CTRL_ADDR;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // poll the interrupt flag, bounded
  task automatic waitSi();
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys);
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (sfrRdata[BIT_SI] !== 1'b1 && n < 15000);
    if (n >= 15000)
      chk(8'h00, 8'h01);
  endtask

  // foreign master on the wire, 125 ns bit clock
  task automatic fmBit(input logic b, output logic s);
    holdSdaLow = ~b;
    #31;
    holdSclLow = 1'b0;
    wait (scl === 1'b1);
    #31;
    s = sda;
    #31;
    holdSclLow = 1'b1;
    #32;
  endtask

  task automatic fmStart();
    holdSdaLow = 1'b1;
    #62;
    holdSclLow = 1'b1;
    #62;
  endtask

  task automatic fmStop();
    holdSdaLow = 1'b1;
    #62;
    holdSclLow = 1'b0;
    wait (scl === 1'b1);
    #62;
    holdSdaLow = 1'b0;
    #62;
  endtask

  // master start plus acknowledged address byte
  task automatic startAddr();
    wr(CTRL_ADDR, 8'h20);
    waitSi();
    rc(CTRL_ADDR, 8'he1);
    chk({7'h0, sclOe}, 8'h01);
    wr(DATA_ADDR, 8'ha6);
    wr(CTRL_ADDR, 8'h00);
    waitSi();
    rc(CTRL_ADDR, 8'hc3);
  endtask

  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #800000;
    error_cnt++;
    $display("CHECK FAILED at %0t: run did not finish in time", $time);
    test_done();
  end

  initial begin
    rst = 1'b1;
    sfrAddr = CTRL_ADDR;
    sfrWe = 1'b0;
    sfrWdata = 8'h00;
    holdSclLow = 1'b0;
    holdSdaLow = 1'b0;
    ackEn = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    // register reset values and access kinds
    rc(CTRL_ADDR, CTRL_RESET);
    rc(CFG_ADDR, 8'h00);
    rc(8'hc5, 8'h00);
    wr(CTRL_ADDR, 8'hcc);
    rc(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h01);
    rc(CTRL_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'h00);
    rc(CTRL_ADDR, 8'h00);
    // master write ended by stop
    startAddr();
    repeat (600) @(posedge clk_sys);
    rc(CTRL_ADDR, 8'hc3);
    wr(CTRL_ADDR, 8'h10);
    rc(CTRL_ADDR, 8'hd0);
    repeat (2500) @(posedge clk_sys);
    rc(CTRL_ADDR, 8'h00);
    chk({6'h0, sclOe, sdaOe}, 8'h00);
    // repeated start lost to a low data line
    startAddr();
    holdSdaLow = 1'b1;
    wr(CTRL_ADDR, 8'h20);
    waitSi();
    rc(CTRL_ADDR, 8'h25);
    wr(CTRL_ADDR, 8'h00);
    rc(CTRL_ADDR, 8'h00);
    fmStop();
    wr(CTRL_ADDR, 8'h00);
    // data byte lost while sending
    startAddr();
    wr(DATA_ADDR, 8'hff);
    holdSdaLow = 1'b1;
    wr(CTRL_ADDR, 8'h00);
    waitSi();
    rc(CTRL_ADDR, 8'h0d);
    wr(CTRL_ADDR, 8'h00);
    fmStop();
    wr(CTRL_ADDR, 8'h00);
    // foreign stop while sending a data byte
    startAddr();
    wr(DATA_ADDR, 8'hff);
    wr(CTRL_ADDR, 8'h00);
    @(posedge scl);
    #200;
    holdSdaLow = 1'b1;
    #200;
    holdSdaLow = 1'b0;
    waitSi();
    rc(CTRL_ADDR, 8'h15);
    wr(CTRL_ADDR, 8'h00);
    // slave receive from a foreign master
    ackEn = 1'b0;
    repeat (20) @(posedge clk_sys);
    fmStart();
    waitSi();
    rc(CTRL_ADDR, 8'h21);
    wr(CTRL_ADDR, 8'h00);
    rv = 8'h5a;
    for (int i = 7; i >= 0; i--)
      fmBit(rv[i], bv);
    waitSi();
    rc(CTRL_ADDR, 8'h09);
    rc(DATA_ADDR, 8'h5a);
    wr(CTRL_ADDR, 8'h02);
    fmBit(1'b1, bv);
    chk({7'h0, bv}, 8'h00);
    wr(CFG_ADDR, 8'h01);
    rv = 8'ha5;
    for (int i = 7; i >= 0; i--)
      fmBit(rv[i], bv);
    waitSi();
    rc(CTRL_ADDR, 8'h03);
    rc(DATA_ADDR, 8'ha5);
    rc(CFG_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'h02);
    fmBit(1'b1, bv);
    chk({7'h0, bv}, 8'h00);
    fmStop();
    waitSi();
    rd(CTRL_ADDR, rv);
    chk(rv & 8'hf1, 8'h11);
    test_done();
  end
endmodule
